// file: core/acl_codec_link.sv
/*
 Codec end of the five-wire audio link: makes the bit clock from the core
 clock, runs cold/warm reset and power-down sequencing, frames both data
 directions and raises codec ready. Assumes the controller pins arrive
 asynchronously and the slot data source sits on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acl_defines.svh"
module acl_codec_link #(
    parameter int PLL_START_CYCLES = `ACL_PLL_START_CYC,
    parameter int READY_CYCLES = `ACL_READY_CYC
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire acl_pkg::acl_link_in_t link_in,
    input wire acl_pkg::acl_clk_src_t clock_source_mode_in,
    input wire logic ate_test_mode_in,
    input wire logic power_down_req_in,
    input wire logic [19:0] tx_slot_data_in,
    output acl_pkg::acl_link_out_t link_out,
    output logic tx_slot_req_out,
    output logic [3:0] tx_slot_index_out,
    output acl_pkg::acl_rx_slot_t rx_slot_out,
    output logic codec_ready_out,
    output logic powered_down_out
);
    import acl_pkg::*;

    localparam int HALF = `ACL_BCLK_HALF_CYC;
    localparam logic [19:0] XTAL_LIM = 20'(`ACL_XTAL_START_CYC);
    localparam logic [19:0] OSC_LIM = 20'(`ACL_OSC_START_CYC);
    localparam logic [19:0] PLL_LIM = 20'(PLL_START_CYCLES);
    localparam logic [19:0] PR4_LIM = 20'(`ACL_PR4_SYNC_CYC);
    localparam logic [19:0] WARM_LIM = 20'(`ACL_WARM_RESTART_CYC);
    localparam logic [19:0] RDY_LIM = 20'(READY_CYCLES);
    localparam logic [2:0] HALF_LAST = 3'(HALF - 1);

    // Slot number holding frame position p
    function automatic logic [3:0] slot_of(input logic [7:0] p);
        logic [7:0] q;
        q = 8'h00;
        if (p < `ACL_SLOT0_BITS)
        begin
            return 4'h0;
        end
        q = (p - `ACL_SLOT0_BITS) / `ACL_SLOT_BITS;
        return 4'(q + 8'h01);
    endfunction

    function automatic logic slot_first(input logic [7:0] p);
        return (p == 8'h00) ||
            (p >= `ACL_SLOT0_BITS && (p - `ACL_SLOT0_BITS) % `ACL_SLOT_BITS == 8'h00);
    endfunction

    function automatic logic slot_last(input logic [7:0] p);
        return (p == `ACL_SLOT0_BITS - 8'h01) ||
            (p >= `ACL_SLOT0_BITS &&
             (p - `ACL_SLOT0_BITS) % `ACL_SLOT_BITS == `ACL_SLOT_BITS - 8'h01);
    endfunction

    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic lrst_n_s;
    logic sync_s;
    logic sdo_s;
    logic ate_s;
    acl_clk_src_t mode_s;
    acl_state_t state_reg;
    acl_clk_src_t mode_reg;
    logic [19:0] cnt_reg;
    logic [19:0] start_lim;
    logic [2:0] div_reg;
    logic bclk_reg;
    logic rise_evt;
    logic fall_evt;
    logic sync_last_reg;
    logic framed_reg;
    logic [7:0] pos_reg;
    logic frame_start;
    logic [7:0] cur_pos;
    logic [7:0] nxt_pos;
    logic [19:0] tx_shift_reg;
    logic sdin_reg;
    logic [19:0] rx_shift_reg;
    logic [19:0] rdy_cnt_reg;
    logic rdy_armed_reg;
    logic ready_reg;
    logic pdown_go;

    // Two-stage synchronisers on every pin from the controller
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            pin_s1_reg <= 6'h00;
            pin_s2_reg <= 6'h00;
        end
        else if (ce_in)
        begin
            pin_s1_reg <= {link_in.reset_n, link_in.sync, link_in.sdata_out,
                           clock_source_mode_in, ate_test_mode_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign lrst_n_s = pin_s2_reg[5];
    assign sync_s = pin_s2_reg[4];
    assign sdo_s = pin_s2_reg[3];
    assign mode_s = acl_clk_src_t'(pin_s2_reg[2:1]);
    assign ate_s = pin_s2_reg[0];

    always_comb
    begin
        case (mode_reg)
            PLL_CLOCK_SOURCE_MODE: start_lim = PLL_LIM;
            EXTERNAL_OSCILLATOR_SOURCE_MODE: start_lim = OSC_LIM;
            default: start_lim = XTAL_LIM;
        endcase
    end

    // Sequencer: cold reset, clock start, power-down and warm reset
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_RESET;
            mode_reg <= CRYSTAL_CLOCK_SOURCE_MODE;
            cnt_reg <= 20'h00000;
        end
        else if (ce_in)
        begin
            if (!lrst_n_s)
            begin
                state_reg <= ST_RESET;
                cnt_reg <= 20'h00000;
            end
            else
            begin
                case (state_reg)
                    ST_RESET:
                    begin
                        cnt_reg <= 20'h00000;
                        // Mode and test strap are caught at reset release
                        if (ate_s)
                        begin
                            state_reg <= ST_TEST;
                        end
                        else
                        begin
                            mode_reg <= mode_s;
                            state_reg <= ST_CLK_WAIT;
                        end
                    end
                    ST_CLK_WAIT:
                    begin
                        if (cnt_reg >= start_lim - 20'h00001)
                        begin
                            state_reg <= ST_RUN;
                            cnt_reg <= 20'h00000;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 20'h00001;
                        end
                    end
                    ST_RUN:
                    begin
                        // Stop right at the end of slot 2, well inside the 1 us bound
                        if (pdown_go)
                        begin
                            state_reg <= ST_PDOWN;
                            cnt_reg <= 20'h00000;
                        end
                    end
                    ST_PDOWN:
                    begin
                        // Short sync blips are not a warm reset
                        if (sync_s)
                        begin
                            if (cnt_reg < PR4_LIM)
                            begin
                                cnt_reg <= cnt_reg + 20'h00001;
                            end
                        end
                        else if (cnt_reg >= PR4_LIM)
                        begin
                            state_reg <= ST_WARM;
                            cnt_reg <= 20'h00000;
                        end
                        else
                        begin
                            cnt_reg <= 20'h00000;
                        end
                    end
                    ST_WARM:
                    begin
                        if (cnt_reg >= WARM_LIM - 20'h00001)
                        begin
                            state_reg <= ST_RUN;
                            cnt_reg <= 20'h00000;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 20'h00001;
                        end
                    end
                    ST_TEST:
                    begin
                        cnt_reg <= 20'h00000;
                    end
                    default:
                    begin
                        state_reg <= ST_RESET;
                    end
                endcase
            end
        end
    end

    // Bit clock divider; 125/10 MHz is the closest even split to nominal
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || state_reg != ST_RUN)
        begin
            div_reg <= 3'h0;
            bclk_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            if (div_reg == HALF_LAST)
            begin
                div_reg <= 3'h0;
                bclk_reg <= ~bclk_reg;
            end
            else
            begin
                div_reg <= div_reg + 3'h1;
            end
        end
    end

    // Link edges as core-clock events
    assign rise_evt = ce_in && state_reg == ST_RUN && div_reg == HALF_LAST && !bclk_reg;
    assign fall_evt = ce_in && state_reg == ST_RUN && div_reg == HALF_LAST && bclk_reg;

    // Frame position: sync seen high on a falling edge marks bit 255 latched
    assign frame_start = fall_evt && sync_s && !sync_last_reg;
    assign cur_pos = frame_start ? `ACL_FRAME_LAST : pos_reg + 8'h01;
    assign nxt_pos = cur_pos + 8'h01;

    // Power-down point: falling event of the last bit of slot 2
    assign pdown_go = fall_evt && framed_reg && power_down_req_in &&
        slot_last(cur_pos) && slot_of(cur_pos) == `ACL_PDOWN_SLOT;

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || state_reg == ST_RESET)
        begin
            sync_last_reg <= 1'b0;
            framed_reg <= 1'b0;
            pos_reg <= 8'h00;
        end
        else if (fall_evt)
        begin
            sync_last_reg <= sync_s;
            pos_reg <= cur_pos;
            if (frame_start)
            begin
                framed_reg <= 1'b1;
            end
        end
    end

    // Ask for the next slot's word one half bit before it is driven
    assign tx_slot_req_out = fall_evt && (framed_reg || frame_start) && slot_first(nxt_pos);
    assign tx_slot_index_out = slot_of(nxt_pos);

    // Transmit shifter; slot 0 word carries ready in its top bit
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || state_reg != ST_RUN || pdown_go) // Data low with the clock stop
        begin
            tx_shift_reg <= 20'h00000;
            sdin_reg <= 1'b0;
        end
        else if (tx_slot_req_out)
        begin
            if (tx_slot_index_out == 4'h0)
            begin
                tx_shift_reg <= {ready_reg, tx_slot_data_in[14:0], 4'h0};
            end
            else
            begin
                tx_shift_reg <= tx_slot_data_in;
            end
        end
        else if (rise_evt)
        begin
            sdin_reg <= tx_shift_reg[19];
            tx_shift_reg <= {tx_shift_reg[18:0], 1'b0};
        end
    end

    // Receive shifter; one record per completed slot
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            rx_shift_reg <= 20'h00000;
            rx_slot_out <= '0;
        end
        else if (ce_in)
        begin
            rx_slot_out.valid <= 1'b0;
            if (fall_evt && framed_reg)
            begin
                rx_shift_reg <= {rx_shift_reg[18:0], sdo_s};
                if (slot_last(cur_pos))
                begin
                    rx_slot_out.valid <= 1'b1;
                    rx_slot_out.index <= slot_of(cur_pos);
                    rx_slot_out.data <= {rx_shift_reg[18:0], sdo_s};
                end
            end
        end
    end

    // Ready counts from the first sync after a cold start; warm reset keeps it
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || state_reg == ST_RESET)
        begin
            rdy_cnt_reg <= 20'h00000;
            rdy_armed_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            if (frame_start)
            begin
                rdy_armed_reg <= 1'b1;
            end
            if (rdy_armed_reg && !ready_reg)
            begin
                if (rdy_cnt_reg >= RDY_LIM - 20'h00002)
                begin
                    ready_reg <= 1'b1;
                end
                rdy_cnt_reg <= rdy_cnt_reg + 20'h00001;
            end
        end
    end

    // Test mode floats both outputs straight from the state flop
    assign link_out.bit_clk = bclk_reg;
    assign link_out.sdata_in = sdin_reg;
    assign link_out.bit_clk_oe = state_reg != ST_TEST;
    assign link_out.sdata_in_oe = state_reg != ST_TEST;
    assign codec_ready_out = ready_reg;
    assign powered_down_out = state_reg == ST_PDOWN || state_reg == ST_WARM;

endmodule
`default_nettype wire

// file: core/acl_defines.svh
/*
 Timing counts and frame geometry constants for the codec-side
 link sequencer. Assumes a 125 MHz core clock; included by the sequencer
 module only.
*/
// Functional notes
// - Bit clock starts 4.0 us after reset, 2.5 ms with PLL.
// - Codec ready set 62.5 us after first sync following start-up.
// - Codec generates the bit clock, nominally 12.288 MHz, for everyone; here 12.5 MHz (125/10).
// - All link data and sync move only on bit clock edges.
// - Frames hold 256 bits in 13 slots; both ends count positions.
// - Codec drives the whole input frame on its data line every frame.
// - After cold reset, codec signals ready only after internal synchronisation.
// - Power-down: stop bit clock, data low within 1.0 us after slot 2.
// - Bit clock restarts no sooner than 162.8 ns after warm sync falls.
// - Test mode: link outputs float within 25 ns of reset rising.
// - Frame starts when sync sampled high on falling bit clock edge.
// - Slot 0 carries 16 tag bits; other twelve slots 20 bits.
// - Read index in output slot 1; data returns in input slot 2.
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

`define ACL_CLK_PERIOD_NS 8.0
`define ACL_BCLK_HALF_NS 40.7
`define ACL_XTAL_START_US 4.0
`define ACL_OSC_START_US 4.0
`define ACL_PLL_START_MS 2.5
`define ACL_READY_US 62.5
`define ACL_PR4_SYNC_US 1.0
`define ACL_WARM_RESTART_NS 285.0
`define ACL_HIZ_MAX_NS 25.0

`define ACL_BCLK_HALF_CYC (int'(`ACL_BCLK_HALF_NS / `ACL_CLK_PERIOD_NS))
`define ACL_XTAL_START_CYC (int'(`ACL_XTAL_START_US * 1000.0 / `ACL_CLK_PERIOD_NS))
`define ACL_OSC_START_CYC (int'(`ACL_OSC_START_US * 1000.0 / `ACL_CLK_PERIOD_NS))
`define ACL_PLL_START_CYC (int'(`ACL_PLL_START_MS * 1000000.0 / `ACL_CLK_PERIOD_NS))
`define ACL_READY_CYC (int'(`ACL_READY_US * 1000.0 / `ACL_CLK_PERIOD_NS))
`define ACL_PR4_SYNC_CYC (int'(`ACL_PR4_SYNC_US * 1000.0 / `ACL_CLK_PERIOD_NS))
`define ACL_WARM_RESTART_CYC (int'(`ACL_WARM_RESTART_NS / `ACL_CLK_PERIOD_NS))

`define ACL_FRAME_LAST 8'hFF
`define ACL_SLOT0_BITS 8'h10
`define ACL_SLOT_BITS 8'h14
`define ACL_PDOWN_SLOT 4'h2
`define ACL_READY_BIT 19

`endif

// file: core/acl_pkg.sv
/*
 Types shared by the codec-side link sequencer and its bench: pin groups,
 clock-source modes, sequencer states and the received-slot record.
 Assumes nothing beyond the constants header.
*/
`default_nettype none
package acl_pkg;

    typedef enum logic [1:0] {
        CRYSTAL_CLOCK_SOURCE_MODE = 2'h0,
        EXTERNAL_OSCILLATOR_SOURCE_MODE = 2'h1,
        PLL_CLOCK_SOURCE_MODE = 2'h2
    } acl_clk_src_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_CLK_WAIT = 3'h1,
        ST_RUN = 3'h2,
        ST_PDOWN = 3'h3,
        ST_WARM = 3'h4,
        ST_TEST = 3'h5
    } acl_state_t;

    // Pins arriving from the controller
    typedef struct packed {
        logic reset_n;
        logic sync;
        logic sdata_out;
    } acl_link_in_t;

    // Pins driven toward the controller, each with its enable
    typedef struct packed {
        logic bit_clk;
        logic bit_clk_oe;
        logic sdata_in;
        logic sdata_in_oe;
    } acl_link_out_t;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [19:0] data;
    } acl_rx_slot_t;

endpackage
`default_nettype wire

// file: test/acl_codec_link_sva.sv
/*
 Port checker for the codec link sequencer.
 Assumes ce_in stays high and a single controller drives the link pins.
*/
`timescale 1ns/1ns
`default_nettype none
module acl_codec_link_sva #(
    parameter int READY_CYCLES = 300
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire acl_pkg::acl_link_in_t link_in,
    input wire logic ate_test_mode_in,
    input wire logic power_down_req_in,
    input wire acl_pkg::acl_link_out_t link_out,
    input wire logic codec_ready_out,
    input wire logic powered_down_out
);
    import acl_pkg::*;
    int sync_cnt_reg;
    logic seen_reg;
    // Cycles since the first sync after a cold reset
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || !link_in.reset_n)
        begin
            seen_reg <= 1'b0;
            sync_cnt_reg <= 0;
        end
        else if (seen_reg || link_in.sync)
        begin
            seen_reg <= 1'b1;
            sync_cnt_reg <= sync_cnt_reg + 1;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_high5;
        link_out.bit_clk [*5] ##1 !link_out.bit_clk;
    endsequence
    // Warm restart may not come sooner than 21 core cycles
    sequence s_quiet21;
        (!link_out.bit_clk) [*8] ##1 (!link_out.bit_clk) [*8] ##1 (!link_out.bit_clk) [*5];
    endsequence
    chk_clk_high: assert property (disable iff (!rst_n_in || !link_in.reset_n)
        $rose(link_out.bit_clk) |-> s_high5) else $error("bit clock high phase wrong");
    chk_clk_low: assert property (disable iff (!rst_n_in || !link_in.reset_n)
        $fell(link_out.bit_clk) && !powered_down_out |-> (!link_out.bit_clk) [*5] ##1 link_out.bit_clk)
        else $error("bit clock low phase wrong");
    chk_pdown_quiet: assert property (powered_down_out |-> !link_out.bit_clk && !link_out.sdata_in)
        else $error("link not quiet in power-down");
    chk_pdown_cause: assert property ($rose(powered_down_out) |->
        $past(power_down_req_in) && $past(link_out.bit_clk)) else $error("unrequested power-down");
    chk_warm_quiet: assert property ($fell(link_in.sync) && powered_down_out |-> s_quiet21)
        else $error("bit clock restarted too soon");
    chk_warm_start: assert property ($fell(powered_down_out) |-> ##[1:6] link_out.bit_clk)
        else $error("bit clock late after warm reset");
    chk_ready_time: assert property ($rose(codec_ready_out) |->
        sync_cnt_reg >= READY_CYCLES && sync_cnt_reg <= READY_CYCLES + 16) else $error("ready timing");
    chk_ready_cold: assert property ($fell(link_in.reset_n) |-> ##[1:4] !codec_ready_out)
        else $error("ready kept over cold reset");
    chk_oe_cause: assert property ($fell(link_out.bit_clk_oe) |-> ate_test_mode_in)
        else $error("outputs floated outside test mode");
    chk_hiz_fast: assert property ($rose(link_in.reset_n) && ate_test_mode_in |->
        ##[1:4] !link_out.sdata_in_oe) else $error("test mode float late");
endmodule
bind acl_codec_link acl_codec_link_sva #(.READY_CYCLES(READY_CYCLES)) u_sva (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .link_in(link_in),
    .ate_test_mode_in(ate_test_mode_in),
    .power_down_req_in(power_down_req_in),
    .link_out(link_out),
    .codec_ready_out(codec_ready_out),
    .powered_down_out(powered_down_out)
);
`default_nettype wire

// file: test/acl_ctrl_model.sv
/*
 Controller model: frames sync and output data on the codec bit clock and
 collects each input slot. Assumes the bench orders cold and warm resets.
*/
`timescale 1ns/1ns
`default_nettype none
module acl_ctrl_model (
    input wire logic bit_clk_in,
    input wire logic cold_n_in,
    input wire logic warm_in,
    input wire logic [19:0] pat_in,
    input wire logic sdata_in_in,
    output acl_pkg::acl_link_in_t pins_out,
    output logic [19:0] word_out,
    output logic [3:0] slot_out,
    output logic [7:0] pos_out,
    output logic done_out
);
    import acl_pkg::*;
    logic [7:0] cnt_reg;
    logic [3:0] s;
    logic [4:0] off;
    logic [19:0] ww;
    // Slot and bit offset of the position on the wire
    assign s = (cnt_reg < 8'h10) ? 4'h0 : 4'((cnt_reg - 8'h10) / 8'h14 + 8'h01);
    assign off = (cnt_reg < 8'h10) ? 5'(cnt_reg) : 5'((cnt_reg - 8'h10) % 8'h14);
    assign ww = (s == 4'h0) ? {pat_in[15:0], 4'h0} : pat_in ^ {s, 16'h0000};
    // Only this side drives reset; sync spans 16 bits, positions FF through 0E
    assign pins_out.reset_n = cold_n_in;
    assign pins_out.sync = warm_in || cnt_reg == 8'hFF || cnt_reg < 8'h0F;
    assign pins_out.sdata_out = ww[19 - off];
    assign pos_out = cnt_reg;
    // Position moves on rising edges; resets leave sync low to avoid a stuck pulse
    always_ff @(posedge bit_clk_in or posedge warm_in or negedge cold_n_in)
    begin
        if (warm_in || !cold_n_in)
            cnt_reg <= 8'hFE;
        else
            cnt_reg <= cnt_reg + 8'h01;
    end
    // Input bits taken on falling edges
    always_ff @(negedge bit_clk_in)
    begin
        word_out <= {word_out[18:0], sdata_in_in};
        done_out <= cnt_reg == 8'h0F || (cnt_reg > 8'h0F && off == 5'h13);
        slot_out <= s;
    end
endmodule
`default_nettype wire

// file: test/acl_codec_link_bench.sv
/*
 Self-checking bench for the codec link sequencer with a controller model.
 Assumes short ready and PLL counts set through parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module acl_codec_link_bench;
    import acl_pkg::*;
    logic clock_in, rst_n_in, ce_in, ate, pdreq, cold_n, warm, chk_on, done, bclk_w, sdi_w;
    logic req, ready, pd;
    acl_clk_src_t mode;
    acl_link_in_t link_in;
    acl_link_out_t link_out;
    acl_rx_slot_t rx;
    logic [19:0] pat, txpat, word, txdata;
    logic [3:0] idx, slot;
    logic [7:0] pos;
    int fails, total_checks, cyc, nslot, n;
    always #4 clock_in = ~clock_in;
    // Pull-downs stand in for floated link outputs
    assign bclk_w = link_out.bit_clk_oe ? link_out.bit_clk : 1'b0;
    assign sdi_w = link_out.sdata_in_oe ? link_out.sdata_in : 1'b0;
    assign txdata = txpat ^ {idx, 16'h0000};
    acl_codec_link #(.PLL_START_CYCLES(200), .READY_CYCLES(300)) u_dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .link_in(link_in),
        .clock_source_mode_in(mode), .ate_test_mode_in(ate), .power_down_req_in(pdreq),
        .tx_slot_data_in(txdata), .link_out(link_out), .tx_slot_req_out(req),
        .tx_slot_index_out(idx), .rx_slot_out(rx), .codec_ready_out(ready),
        .powered_down_out(pd));
    acl_ctrl_model u_ctrl (.bit_clk_in(bclk_w), .cold_n_in(cold_n), .warm_in(warm), .pat_in(pat),
        .sdata_in_in(sdi_w), .pins_out(link_in), .word_out(word), .slot_out(slot),
        .pos_out(pos), .done_out(done));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_for(input logic want, input int lim);
        n = 0;
        while (((lim > 2000) ? pd : bclk_w) !== want && n < lim)
        begin
            @(negedge clock_in);
            n++;
        end
    endtask
    // Cold reset with new straps; both resets pulsed so either capture point sees them
    task automatic cold_start(input acl_clk_src_t m, input logic t, input int exp);
        @(negedge clock_in);
        cold_n = 0;
        rst_n_in = 0;
        mode = m;
        ate = t;
        repeat (4) @(negedge clock_in);
        rst_n_in = 1;
        repeat (130) @(negedge clock_in);
        cold_n = 1;
        wait_for(1'b1, 800);
        check(n >= exp && n <= exp + 16, 1);
        check({link_out.bit_clk_oe, link_out.sdata_in_oe}, {2{!t}});
    endtask
    // Fresh patterns, two settling frames, then two checked frames
    task automatic run_frames(input logic [19:0] p, input logic [19:0] tp);
        @(negedge clock_in);
        chk_on = 0;
        pat = p;
        txpat = tp;
        repeat (5200) @(negedge clock_in);
        chk_on = 1;
        repeat (5200) @(negedge clock_in);
        check(ready, 1);
    endtask
    // Slots received by the codec, and slot count per frame
    always @(posedge clock_in)
        if (rx.valid === 1'b1)
        begin
            if (chk_on && rx.index === 4'h0 && nslot > 0)
                check(nslot, 13);
            if (chk_on && rx.index === 4'h0)
                check(rx.data[15:0], pat[15:0]);
            else if (chk_on)
                check(rx.data, pat ^ {rx.index, 16'h0000});
            nslot <= (rx.index === 4'h0) ? 1 : nslot + 1;
        end
    // Slots sent by the codec, as collected by the controller
    always @(posedge bclk_w)
        if (chk_on && done === 1'b1)
        begin
            if (slot === 4'h0)
                check(word[15:0], {ready, txpat[14:0]});
            else
                check(word, txpat ^ {slot, 16'h0000});
        end
    // Slot 0 word is asked for while the controller shows the last bit
    always @(posedge clock_in)
        if (chk_on && req === 1'b1 && idx === 4'h0)
            check(pos, 8'hFF);
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fails++;
            results();
        end
    end
    initial
    begin
        {clock_in, rst_n_in, ate, pdreq, cold_n, warm, chk_on} = 7'h00;
        {ce_in, mode, pat, txpat, fails, total_checks, cyc, nslot} = '0;
        ce_in = 1;
        void'($urandom(32'hDCF9));
        repeat (4) @(negedge clock_in);
        rst_n_in = 1;
        cold_start(CRYSTAL_CLOCK_SOURCE_MODE, 1'b1, 800);
        cold_start(PLL_CLOCK_SOURCE_MODE, 1'b0, 200);
        cold_start(EXTERNAL_OSCILLATOR_SOURCE_MODE, 1'b0, 500);
        cold_start(CRYSTAL_CLOCK_SOURCE_MODE, 1'b0, 500);
        run_frames(20'hFFFFF, 20'h00000);
        run_frames(20'h00000, 20'hFFFFF);
        run_frames(20'($urandom), 20'($urandom));
        // Power-down lands after slot 2; short sync ignored, long one wakes
        @(negedge clock_in);
        chk_on = 0;
        pdreq = 1;
        wait_for(1'b1, 3000);
        pdreq = 0;
        check(pos, 8'h37);
        repeat (50) @(negedge clock_in);
        warm = 1;
        repeat (60) @(negedge clock_in);
        warm = 0;
        repeat (100) @(negedge clock_in);
        check(pd, 1);
        warm = 1;
        repeat (130) @(negedge clock_in);
        warm = 0;
        wait_for(1'b1, 200);
        check(n >= 21 && n <= 60, 1);
        run_frames(20'($urandom), 20'($urandom));
        results();
    end
endmodule
`default_nettype wire
